// file: core/dsd_decoder.sv
`timescale 1ns/10ps
`include "dsd_regs.svh"
module dsd_decoder #(
	parameter int unsigned ATOMIC_CYC = int'(`DSD_T_ATOMIC_MS * 1000.0 * `DSD_CLK_MHZ),
	parameter int unsigned SPLIT_CYC = int'(`DSD_T_SPLIT_MS * 1000.0 * `DSD_CLK_MHZ)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire dsd_pkg::dsd_kind_t req_kind,
	input wire dsd_pkg::dsd_mode_t req_mode,
	input wire dsd_pkg::dsd_ptr_t req_ptr,
	input wire logic [15:0] req_addr,
	input wire logic [5:0] req_io,
	input wire logic [2:0] req_bit,
	input wire logic [5:0] req_disp,
	input wire logic [7:0] req_wdata,
	output logic resp_valid,
	output logic [7:0] resp_rdata,
	output logic resp_skip,
	output logic resp_err,
	input wire logic [4:0] gpr_rd_addr,
	output logic [7:0] gpr_rd_data,
	input wire logic gpr_we,
	input wire logic [4:0] gpr_wr_addr,
	input wire logic [7:0] gpr_wr_data,
	input wire logic [7:0] flag_set,
	output logic nvm_busy,
	output logic nvm_ready_req
);
	// Low register of a pointer pair
	function automatic logic [4:0] ptr_base(input dsd_pkg::dsd_ptr_t p);
		unique case (p)
			dsd_pkg::P_X: ptr_base = `DSD_PTR_X;
			dsd_pkg::P_Y: ptr_base = `DSD_PTR_Y;
			default: ptr_base = `DSD_PTR_Z;
		endcase
	endfunction

	// Address-below-limit test used by every region decode
	function automatic logic below(input logic [15:0] a, input logic [15:0] lim);
		below = a < lim;
	endfunction

	logic [7:0] gpr_q [32];
	logic [7:0] gpr_d [32];
	logic [7:0] flags_q, flags_d, ext_q;
	logic [7:0] scr_q [4];
	dsd_pkg::dsd_state_t state_q, state_d;
	logic [2:0] wait_q, wait_d, wait_n;
	logic sram_q, resp_d, skip_d, err_d;
	logic [7:0] rdata_d;
	logic [7:0] rd_mux;

	wire take = req_valid & req_ready;
	wire is_ls = (req_kind == dsd_pkg::K_LOAD) || (req_kind == dsd_pkg::K_STORE);
	wire is_bit = req_kind[2];
	wire is_wr = (req_kind == dsd_pkg::K_STORE) || (req_kind == dsd_pkg::K_IO_OUT) ||
		(req_kind == dsd_pkg::K_BIT_SET) || (req_kind == dsd_pkg::K_BIT_CLR);

	// Pointer pair read straight from the working registers
	wire [4:0] pidx = ptr_base(req_ptr);
	wire [4:0] pidx_hi = {pidx[4:1], 1'b1};
	wire [15:0] ptr_cur = {gpr_q[pidx_hi], gpr_q[pidx]};
	wire [15:0] ptr_dec = ptr_cur - 16'h0001;
	wire [15:0] ptr_inc = ptr_cur + 16'h0001;
	wire [15:0] ptr_disp = ptr_cur + {10'h000, req_disp};

	// Effective address per addressing mode
	wire [15:0] ls_addr = (req_mode == dsd_pkg::M_DIRECT) ? req_addr :
		(req_mode == dsd_pkg::M_DISP) ? ptr_disp :
		(req_mode == dsd_pkg::M_PREDEC) ? ptr_dec : ptr_cur;
	// Six-bit I/O address cannot pass 0x5f, so extended I/O stays out of reach
	wire [15:0] io_addr = {10'h000, req_io} + `DSD_IO_OFS;
	wire [15:0] eff = is_ls ? ls_addr : io_addr;

	// Refusals: bit ops beyond low I/O, X with displacement, bad mode codes
	wire bad_bit = is_bit && (req_io > `DSD_BITIO_MAX);
	wire bad_disp = is_ls && (req_mode == dsd_pkg::M_DISP) && (req_ptr == dsd_pkg::P_X);
	wire bad_mode = is_ls && (req_mode > dsd_pkg::M_POSTINC);
	wire bad_ptr = is_ls && (req_mode != dsd_pkg::M_DIRECT) && (req_ptr == 2'h3);
	wire bad = bad_bit | bad_disp | bad_mode | bad_ptr;
	wire go = take & ~bad;

	// Region decode in ascending order
	wire rg_gpr = below(eff, `DSD_GPR_END);
	wire rg_io = ~rg_gpr & below(eff, `DSD_IO_END);
	wire rg_ext = ~below(eff, `DSD_IO_END) & below(eff, `DSD_EXT_END);
	wire rg_sram = ~below(eff, `DSD_SRAM_BASE) & below(eff, `DSD_SRAM_END);
	wire hit_nvctl = rg_io && (eff == `DSD_A_NVCTL);
	wire hit_nvdat = rg_io && (eff == `DSD_A_NVDAT);
	wire hit_nvadl = rg_io && (eff == `DSD_A_NVADL);
	wire hit_nvadh = rg_io && (eff == `DSD_A_NVADH);
	wire hit_flags = rg_io && (eff == `DSD_A_FLAGS);
	wire hit_scr = rg_io && ((eff & `DSD_SCR_MASK) == `DSD_A_SCR);
	wire hit_ext = rg_ext && (eff == `DSD_A_EXT);

	// Write value: bit ops are read-modify-write of one bit only
	wire [7:0] bmask = 8'h01 << req_bit;
	wire [7:0] wval = (req_kind == dsd_pkg::K_BIT_SET) ? (rd_mux | bmask) :
		(req_kind == dsd_pkg::K_BIT_CLR) ? (rd_mux & ~bmask) : req_wdata;
	// Flag clear mask: a bit set names only its own bit, a bit clear names none
	wire [7:0] fclr = (req_kind == dsd_pkg::K_BIT_SET) ? bmask :
		(req_kind == dsd_pkg::K_BIT_CLR) ? 8'h00 : req_wdata;
	wire wr_go = go & is_wr;
	wire bit_val = |(rd_mux & bmask);
	wire skip_n = ((req_kind == dsd_pkg::K_SKIP_ONE) & bit_val) | ((req_kind == dsd_pkg::K_SKIP_ZERO) & ~bit_val);
	wire ptr_upd = go & is_ls & ((req_mode == dsd_pkg::M_PREDEC) | (req_mode == dsd_pkg::M_POSTINC));
	wire [15:0] ptr_new = (req_mode == dsd_pkg::M_PREDEC) ? ptr_dec : ptr_inc;

	logic [7:0] nv_ctrl, nv_data, nv_adl, nv_adh, sram_rdata, nvm_rdata;
	logic nv_rd_fire, nv_wr_fire, nvm_re, nvm_we;
	logic [`DSD_NVM_AW-1:0] nvm_addr;
	logic [7:0] nvm_wdata;
	wire [15:0] sram_off = eff - `DSD_SRAM_BASE;

	assign req_ready = state_q == dsd_pkg::S_IDLE;
	assign gpr_rd_data = gpr_q[gpr_rd_addr];

	// Read mux for all single-cycle regions; holes read zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (rg_gpr)
			rd_mux = gpr_q[eff[4:0]];
		else if (hit_nvctl)
			rd_mux = nv_ctrl;
		else if (hit_nvdat)
			rd_mux = nv_data;
		else if (hit_nvadl)
			rd_mux = nv_adl;
		else if (hit_nvadh)
			rd_mux = nv_adh;
		else if (hit_flags)
			rd_mux = flags_q;
		else if (hit_scr)
			rd_mux = scr_q[eff[1:0]];
		else if (hit_ext)
			rd_mux = ext_q;
	end

	// Register file next state; pointer update wins over a data write
	always_comb
	begin
		gpr_d = gpr_q;
		if (gpr_we)
			gpr_d[gpr_wr_addr] = gpr_wr_data;
		if (wr_go && rg_gpr)
			gpr_d[eff[4:0]] = wval;
		if (ptr_upd)
		begin
			gpr_d[pidx] = ptr_new[7:0];
			gpr_d[pidx_hi] = ptr_new[15:8];
		end
	end

	// Event set beats a same-cycle write-one clear
	assign flags_d = (flags_q & ~((wr_go & hit_flags) ? fclr : 8'h00)) | flag_set;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			for (int i = 0; i < 32; i++)
				gpr_q[i] <= '0;
			flags_q <= '0;
		end
		else
		begin
			gpr_q <= gpr_d;
			flags_q <= flags_d;
		end

	// Scratch registers; writes to other holes are dropped
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			for (int i = 0; i < 4; i++)
				scr_q[i] <= '0;
			ext_q <= '0;
		end
		else if (wr_go && hit_scr)
			scr_q[eff[1:0]] <= wval;
		else if (wr_go && hit_ext)
			ext_q <= wval;

	// Wait length: SRAM second cycle, NVM stalls after a read or a write start
	assign wait_n = bad ? 3'h0 : rg_sram ? `DSD_SRAM_WAIT :
		nv_rd_fire ? `DSD_RD_STALL : nv_wr_fire ? `DSD_WR_STALL : 3'h0;

	always_comb
	begin
		state_d = state_q;
		wait_d = wait_q;
		resp_d = 1'b0;
		rdata_d = resp_rdata;
		skip_d = resp_skip;
		err_d = resp_err;
		unique case (state_q)
			dsd_pkg::S_IDLE:
				if (take)
				begin
					rdata_d = bad ? 8'h00 : rd_mux;
					skip_d = ~bad & skip_n;
					err_d = bad;
					wait_d = wait_n;
					if (wait_n == 3'h0)
						resp_d = 1'b1;
					else
						state_d = dsd_pkg::S_WAIT;
				end
			dsd_pkg::S_WAIT:
			begin
				wait_d = wait_q - 3'h1;
				if (wait_q == 3'h1)
				begin
					state_d = dsd_pkg::S_IDLE;
					resp_d = 1'b1;
					if (sram_q)
						rdata_d = sram_rdata;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			state_q <= dsd_pkg::S_IDLE;
			wait_q <= '0;
			sram_q <= 1'b0;
			resp_valid <= 1'b0;
			resp_rdata <= '0;
			resp_skip <= 1'b0;
			resp_err <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wait_q <= wait_d;
			if (take)
				sram_q <= go & rg_sram;
			resp_valid <= resp_d;
			resp_rdata <= rdata_d;
			resp_skip <= skip_d;
			resp_err <= err_d;
		end

	// Internal data SRAM, registered read
	dsd_mem #(.AW(`DSD_SRAM_AW)) u_sram (
		.clk(clk),
		.rst_n(rst_n),
		.re(go & rg_sram & ~is_wr),
		.we(wr_go & rg_sram),
		.addr(sram_off[`DSD_SRAM_AW-1:0]),
		.wdata(wval),
		.rdata(sram_rdata)
	);

	// NVM byte array, no reset of contents
	dsd_mem #(.AW(`DSD_NVM_AW)) u_nvm_arr (
		.clk(clk),
		.rst_n(por_n),
		.re(nvm_re),
		.we(nvm_we),
		.addr(nvm_addr),
		.wdata(nvm_wdata),
		.rdata(nvm_rdata)
	);

	// NVM access registers sit in low I/O
	dsd_nvm #(.ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC)) u_nvm (
		.clk(clk),
		.rst_n(rst_n),
		.por_n(por_n),
		.ctrl_we(wr_go & hit_nvctl),
		.data_we(wr_go & hit_nvdat),
		.addrl_we(wr_go & hit_nvadl),
		.addrh_we(wr_go & hit_nvadh),
		.wdata(wval),
		.ctrl_rd(nv_ctrl),
		.data_rd(nv_data),
		.addrl_rd(nv_adl),
		.addrh_rd(nv_adh),
		.rd_fire(nv_rd_fire),
		.wr_fire(nv_wr_fire),
		.busy(nvm_busy),
		.ready_req(nvm_ready_req),
		.mem_re(nvm_re),
		.mem_we(nvm_we),
		.mem_addr(nvm_addr),
		.mem_wdata(nvm_wdata),
		.mem_rdata(nvm_rdata)
	);
endmodule // dsd_decoder

// file: core/dsd_regs.svh
`ifndef DSD_REGS_SVH
`define DSD_REGS_SVH
// Data-space region limits (exclusive upper bounds)
`define DSD_GPR_END 16'h0020
`define DSD_IO_END 16'h0060
`define DSD_EXT_END 16'h0100
`define DSD_SRAM_BASE 16'h0100
`define DSD_SRAM_END 16'h0500
`define DSD_SRAM_AW 10
`define DSD_NVM_AW 11
// I/O to data-space offset and bit-instruction reach
`define DSD_IO_OFS 16'h0020
`define DSD_BITIO_MAX 6'h1f
// Pointer pair low register indices
`define DSD_PTR_X 5'h1a
`define DSD_PTR_Y 5'h1c
`define DSD_PTR_Z 5'h1e
// Register data-space addresses
`define DSD_A_NVCTL 16'h0030
`define DSD_A_NVDAT 16'h0031
`define DSD_A_NVADL 16'h0032
`define DSD_A_NVADH 16'h0033
`define DSD_A_FLAGS 16'h0038
`define DSD_A_SCR 16'h003c
`define DSD_SCR_MASK 16'hfffc
`define DSD_A_EXT 16'h0060
// NVM control field positions
`define DSD_CB_RD 0
`define DSD_CB_WR 1
`define DSD_CB_ARM 2
`define DSD_CB_RIE 3
`define DSD_CB_PM 4
`define DSD_PM_ATOMIC 2'h0
`define DSD_PM_ERASE 2'h1
`define DSD_PM_RSVD 2'h3
`define DSD_ERASED 8'hff
// Cycle figures
`define DSD_ARM_CYC 3'h4
`define DSD_RD_STALL 3'h4
`define DSD_WR_STALL 3'h2
`define DSD_SRAM_WAIT 3'h1
`define DSD_PCW 18
`define DSD_CLK_MHZ 50
`define DSD_T_ATOMIC_MS 3.4
`define DSD_T_SPLIT_MS 1.8
`endif

// file: core/dsd_pkg.sv
package dsd_pkg;
	typedef enum logic [2:0] {
		K_LOAD = 3'h0, K_STORE = 3'h1, K_IO_IN = 3'h2, K_IO_OUT = 3'h3,
		K_BIT_SET = 3'h4, K_BIT_CLR = 3'h5, K_SKIP_ONE = 3'h6, K_SKIP_ZERO = 3'h7
	} dsd_kind_t;
	typedef enum logic [2:0] {
		M_DIRECT = 3'h0, M_INDIRECT = 3'h1, M_DISP = 3'h2, M_PREDEC = 3'h3, M_POSTINC = 3'h4
	} dsd_mode_t;
	typedef enum logic [1:0] {P_X = 2'h0, P_Y = 2'h1, P_Z = 2'h2} dsd_ptr_t;
	typedef enum logic {S_IDLE = 1'b0, S_WAIT = 1'b1} dsd_state_t;
	typedef enum logic [1:0] {N_IDLE = 2'h0, N_OLD = 2'h1, N_PROG = 2'h2} dsd_nvst_t;
endpackage

// file: core/dsd_mem.sv
`timescale 1ns/10ps
module dsd_mem #(
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic re,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem_q [2**AW];

	// Array has no reset; contents are undefined until written
	always_ff @(posedge clk)
		if (we)
			mem_q[addr] <= wdata;

	// Registered read port
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			rdata <= '0;
		else if (re)
			rdata <= mem_q[addr];
endmodule // dsd_mem

// file: core/dsd_nvm.sv
`timescale 1ns/10ps
`include "dsd_regs.svh"
module dsd_nvm #(
	parameter int unsigned ATOMIC_CYC = 170000,
	parameter int unsigned SPLIT_CYC = 90000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic ctrl_we,
	input wire logic data_we,
	input wire logic addrl_we,
	input wire logic addrh_we,
	input wire logic [7:0] wdata,
	output logic [7:0] ctrl_rd,
	output logic [7:0] data_rd,
	output logic [7:0] addrl_rd,
	output logic [7:0] addrh_rd,
	output logic rd_fire,
	output logic wr_fire,
	output logic busy,
	output logic ready_req,
	output logic mem_re,
	output logic mem_we,
	output logic [`DSD_NVM_AW-1:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata
);
	dsd_pkg::dsd_nvst_t st_q, st_d;
	logic [`DSD_PCW-1:0] cnt_q, cnt_d;
	logic [`DSD_NVM_AW-1:0] addr_q, pa_q;
	logic [7:0] data_q, pd_q, old_q;
	logic [1:0] mode_q, pm_q;
	logic [2:0] arm_q;
	logic rie_q, rd_pend_q, arm;

	assign busy = st_q != dsd_pkg::N_IDLE;
	assign arm = arm_q != 3'h0;
	assign ctrl_rd = {2'h0, mode_q, rie_q, arm, busy, 1'b0};
	assign data_rd = data_q;
	assign addrl_rd = addr_q[7:0];
	assign addrh_rd = {5'h00, addr_q[`DSD_NVM_AW-1:8]};
	assign ready_req = rie_q & ~busy;
	// Strobe counts only while still armed from an earlier write
	assign wr_fire = ctrl_we & wdata[`DSD_CB_WR] & arm & ~busy & (mode_q != `DSD_PM_RSVD);
	assign rd_fire = ctrl_we & wdata[`DSD_CB_RD] & ~busy;
	assign mem_re = rd_fire | wr_fire;
	assign mem_addr = busy ? pa_q : addr_q;
	assign mem_we = (st_q == dsd_pkg::N_PROG) && (cnt_q == `DSD_PCW'(1));
	assign mem_wdata = (pm_q == `DSD_PM_ATOMIC) ? pd_q : (pm_q == `DSD_PM_ERASE) ? `DSD_ERASED : (old_q & pd_q);

	// Programming sequencer: old byte, then self-timed countdown
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			dsd_pkg::N_IDLE:
				if (wr_fire)
				begin
					st_d = dsd_pkg::N_OLD;
					cnt_d = (mode_q == `DSD_PM_ATOMIC) ? `DSD_PCW'(ATOMIC_CYC) : `DSD_PCW'(SPLIT_CYC);
				end
			dsd_pkg::N_OLD:
				st_d = dsd_pkg::N_PROG;
			dsd_pkg::N_PROG:
			begin
				cnt_d = cnt_q - `DSD_PCW'(1);
				if (cnt_q == `DSD_PCW'(1))
					st_d = dsd_pkg::N_IDLE;
			end
			default:
				st_d = dsd_pkg::N_IDLE;
		endcase
	end

	// Only power-on clears a write in flight, so a plain reset lets it finish
	always_ff @(posedge clk or negedge por_n)
		if (!por_n)
		begin
			st_q <= dsd_pkg::N_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end

	// Latched write operands, also power-on domain
	always_ff @(posedge clk or negedge por_n)
		if (!por_n)
		begin
			pa_q <= '0;
			pd_q <= '0;
			pm_q <= '0;
			old_q <= '0;
		end
		else if (wr_fire)
		begin
			pa_q <= addr_q;
			pd_q <= data_q;
			pm_q <= mode_q;
		end
		else if (st_q == dsd_pkg::N_OLD)
			old_q <= mem_rdata;

	// Mode survives reset while busy; writes ignored while busy
	always_ff @(posedge clk or negedge por_n)
		if (!por_n)
			mode_q <= '0;
		else if (!rst_n && !busy)
			mode_q <= '0;
		else if (rst_n && ctrl_we && !busy)
			mode_q <= wdata[`DSD_CB_PM+1:`DSD_CB_PM];

	// Arming window reloads on each write of the arm bit
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			arm_q <= '0;
		else if (ctrl_we && wdata[`DSD_CB_ARM])
			arm_q <= `DSD_ARM_CYC;
		else if (arm)
			arm_q <= arm_q - 3'h1;

	// Software side registers
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			addr_q <= '0;
			data_q <= '0;
			rie_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end
		else
		begin
			rd_pend_q <= rd_fire;
			if (ctrl_we)
				rie_q <= wdata[`DSD_CB_RIE];
			if (addrl_we && !busy)
				addr_q[7:0] <= wdata;
			if (addrh_we && !busy)
				addr_q[`DSD_NVM_AW-1:8] <= wdata[`DSD_NVM_AW-9:0];
			if (data_we)
				data_q <= wdata;
			else if (rd_pend_q)
				data_q <= mem_rdata;
		end
endmodule // dsd_nvm

// file: sim/dsd_decoder_sva.sv
`timescale 1ns/10ps
// Watches the CPU-side request and answer timing of the decoder
module dsd_decoder_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire dsd_pkg::dsd_kind_t req_kind,
	input wire dsd_pkg::dsd_mode_t req_mode,
	input wire dsd_pkg::dsd_ptr_t req_ptr,
	input wire logic [15:0] req_addr,
	input wire logic [5:0] req_io,
	input wire logic [7:0] req_wdata,
	input wire logic resp_valid,
	input wire logic [7:0] resp_rdata,
	input wire logic resp_err,
	input wire logic nvm_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Request classes at the taking edge
	wire take = req_valid && req_ready;
	wire is_ld = req_kind == dsd_pkg::K_LOAD;
	wire is_ls = is_ld || req_kind == dsd_pkg::K_STORE;
	wire dir = req_mode == dsd_pkg::M_DIRECT;
	wire to_sram = take && is_ls && dir && req_addr >= 16'h0100 && req_addr <= 16'h04ff;
	wire bit_op = take && req_kind[2];
	wire nvm_rd = take && !is_ld && is_ls && dir && req_addr == 16'h0030 && req_wdata == 8'h01 && !nvm_busy;
	// Wait shapes: one idle cycle for SRAM, four for a store that reads the array
	sequence gap1_s;
		!resp_valid ##1 resp_valid;
	endsequence
	sequence stall4_s;
		!resp_valid [*4] ##1 resp_valid;
	endsequence
	sram_two_cycle_a: assert property (to_sram |=> gap1_s) else $error("sram answer not in second cycle");
	sram_ready_low_a: assert property (to_sram |=> !req_ready) else $error("ready high during sram wait");
	io_read_plain_a: assert property (take && req_kind == dsd_pkg::K_IO_IN |=> resp_valid && !resp_err)
		else $error("io read answer late or refused");
	bit_range_err_a: assert property (bit_op && req_io > 6'h1f |=> resp_valid && resp_err && resp_rdata == 8'h00)
		else $error("bit op above 0x1f not refused");
	bit_low_ok_a: assert property (bit_op && req_io <= 6'h1f |=> !resp_err) else $error("low bit op refused");
	unmapped_zero_a: assert property (take && is_ld && dir && req_addr >= 16'h0500 |=> resp_valid
		&& resp_rdata == 8'h00 && !resp_err) else $error("unmapped read not zero");
	disp_x_err_a: assert property (take && is_ls && req_mode == dsd_pkg::M_DISP && req_ptr == dsd_pkg::P_X
		|=> resp_valid && resp_err) else $error("displacement on X not refused");
	nvm_read_stall_a: assert property (nvm_rd |=> stall4_s) else $error("array read stall not four");
	cover property (to_sram);
endmodule // dsd_decoder_chk
bind dsd_decoder dsd_decoder_chk chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
	.req_kind(req_kind), .req_mode(req_mode), .req_ptr(req_ptr), .req_addr(req_addr), .req_io(req_io),
	.req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_err(resp_err),
	.nvm_busy(nvm_busy));

// file: sim/dsd_cpu_model.sv
`timescale 1ns/10ps
// CPU core stand-in: one request at a time, held until the decoder takes it
module dsd_cpu_model (
	input wire logic clk,
	input wire logic req_ready,
	input wire logic resp_valid,
	input wire logic [7:0] resp_rdata,
	input wire logic resp_skip,
	input wire logic resp_err,
	output logic req_valid,
	output dsd_pkg::dsd_kind_t req_kind,
	output dsd_pkg::dsd_mode_t req_mode,
	output dsd_pkg::dsd_ptr_t req_ptr,
	output logic [15:0] req_addr,
	output logic [5:0] req_io,
	output logic [2:0] req_bit,
	output logic [5:0] req_disp,
	output logic [7:0] req_wdata
);
	logic [7:0] got_rd;
	logic got_skip, got_err;
	int lat;
	initial
	begin
		req_valid = 1'b0;
		req_kind = dsd_pkg::K_LOAD;
		req_mode = dsd_pkg::M_DIRECT;
		req_ptr = dsd_pkg::P_X;
		req_addr = 16'h0000;
		req_io = 6'h00;
		req_bit = 3'h0;
		req_disp = 6'h00;
		req_wdata = 8'h00;
	end
	// Entered just after an edge; a missing answer leaves unknowns so any compare fails
	task automatic issue(input dsd_pkg::dsd_kind_t k, input dsd_pkg::dsd_mode_t m, input dsd_pkg::dsd_ptr_t p,
		input logic [15:0] a, input logic [5:0] io, input logic [2:0] b, input logic [5:0] d, input logic [7:0] w);
		int n;
		req_kind = k;
		req_mode = m;
		req_ptr = p;
		req_addr = a;
		req_io = io;
		req_bit = b;
		req_disp = d;
		req_wdata = w;
		req_valid = 1'b1;
		n = 0;
		while (!req_ready && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		req_addr = ~a; // Released: no stale address
		req_wdata = ~w;
		lat = 1;
		while (!resp_valid && lat < 50)
		begin
			@(posedge clk);
			#1;
			lat++;
		end
		got_rd = resp_valid ? resp_rdata : 8'hxx;
		got_skip = resp_valid ? resp_skip : 1'bx;
		got_err = resp_valid ? resp_err : 1'bx;
		@(posedge clk);
		#1;
	endtask
	// Armed write: arm alone, then strobe in the next request; mode bits ride along, reserved stay zero
	task automatic nvm_prog(input logic [7:0] pm);
		issue(dsd_pkg::K_STORE, dsd_pkg::M_DIRECT, dsd_pkg::P_X, 16'h0030, 6'h00, 3'h0, 6'h00, 8'h04 | pm);
		issue(dsd_pkg::K_STORE, dsd_pkg::M_DIRECT, dsd_pkg::P_X, 16'h0030, 6'h00, 3'h0, 6'h00, 8'h02 | pm);
	endtask
endmodule // dsd_cpu_model

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clk, rst_n, por_n, gpr_we, req_valid, req_ready, resp_valid, resp_skip, resp_err, nvm_busy, nvm_rdy;
	logic [4:0] gpr_rd_addr, gpr_wr_addr;
	logic [7:0] gpr_wr_data, flag_set, gpr_rd_data, resp_rdata, req_wdata;
	dsd_pkg::dsd_kind_t req_kind;
	dsd_pkg::dsd_mode_t req_mode;
	dsd_pkg::dsd_ptr_t req_ptr;
	logic [15:0] req_addr;
	logic [5:0] req_io, req_disp;
	logic [2:0] req_bit;
	int fails = 0;
	int compares = 0;
	int n;
	// Direct-mode request, expected read value, skip, refusal and answer latency
	typedef struct packed {logic [2:0] k; logic [15:0] a; logic [5:0] io; logic [2:0] b; logic [7:0] w;
		logic [7:0] erd; logic cmp; logic esk; logic eerr; logic [2:0] lat;} dsd_row_t;
	dsd_row_t r;
	dsd_row_t rows [21] = '{
		'{3'h1, 16'h0100, 6'h00, 3'h0, 8'ha5, 8'h00, 1'b0, 1'b0, 1'b0, 3'h2},
		'{3'h0, 16'h0100, 6'h00, 3'h0, 8'h00, 8'ha5, 1'b1, 1'b0, 1'b0, 3'h2},
		'{3'h1, 16'h04ff, 6'h00, 3'h0, 8'h3c, 8'h00, 1'b0, 1'b0, 1'b0, 3'h2},
		'{3'h0, 16'h04ff, 6'h00, 3'h0, 8'h00, 8'h3c, 1'b1, 1'b0, 1'b0, 3'h2},
		'{3'h3, 16'h0000, 6'h1c, 3'h0, 8'h96, 8'h00, 1'b0, 1'b0, 1'b0, 3'h1},
		'{3'h0, 16'h003c, 6'h00, 3'h0, 8'h00, 8'h96, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h1, 16'h003d, 6'h00, 3'h0, 8'h11, 8'h00, 1'b0, 1'b0, 1'b0, 3'h1},
		'{3'h2, 16'h0000, 6'h1d, 3'h0, 8'h00, 8'h11, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h1, 16'h0060, 6'h00, 3'h0, 8'h77, 8'h00, 1'b0, 1'b0, 1'b0, 3'h1},
		'{3'h0, 16'h0060, 6'h00, 3'h0, 8'h00, 8'h77, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h1, 16'h0600, 6'h00, 3'h0, 8'hee, 8'h00, 1'b0, 1'b0, 1'b0, 3'h1},
		'{3'h0, 16'h0600, 6'h00, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h4, 16'h0000, 6'h1c, 3'h0, 8'h00, 8'h96, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h5, 16'h0000, 6'h1c, 3'h7, 8'h00, 8'h97, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h0, 16'h003c, 6'h00, 3'h0, 8'h00, 8'h17, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h6, 16'h0000, 6'h1c, 3'h0, 8'h00, 8'h17, 1'b1, 1'b1, 1'b0, 3'h1},
		'{3'h7, 16'h0000, 6'h1c, 3'h7, 8'h00, 8'h17, 1'b1, 1'b1, 1'b0, 3'h1},
		'{3'h6, 16'h0000, 6'h1c, 3'h7, 8'h00, 8'h17, 1'b1, 1'b0, 1'b0, 3'h1},
		'{3'h4, 16'h0000, 6'h20, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 3'h1},
		'{3'h7, 16'h0000, 6'h3f, 3'h1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 3'h1},
		'{3'h5, 16'h0000, 6'h1f, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 3'h1}};
	// Short write counts keep the run brief
	dsd_decoder #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) dut (.clk(clk), .rst_n(rst_n), .por_n(por_n),
		.req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_mode(req_mode), .req_ptr(req_ptr),
		.req_addr(req_addr), .req_io(req_io), .req_bit(req_bit), .req_disp(req_disp), .req_wdata(req_wdata),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_skip(resp_skip), .resp_err(resp_err),
		.gpr_rd_addr(gpr_rd_addr), .gpr_rd_data(gpr_rd_data), .gpr_we(gpr_we), .gpr_wr_addr(gpr_wr_addr),
		.gpr_wr_data(gpr_wr_data), .flag_set(flag_set), .nvm_busy(nvm_busy), .nvm_ready_req(nvm_rdy));
	dsd_cpu_model cpu (.clk(clk), .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.resp_skip(resp_skip), .resp_err(resp_err), .req_valid(req_valid), .req_kind(req_kind), .req_mode(req_mode),
		.req_ptr(req_ptr), .req_addr(req_addr), .req_io(req_io), .req_bit(req_bit), .req_disp(req_disp),
		.req_wdata(req_wdata));
	task automatic stop_test;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic ld(input logic [15:0] a, input logic [7:0] e);
		cpu.issue(dsd_pkg::K_LOAD, dsd_pkg::M_DIRECT, dsd_pkg::P_X, a, 6'h00, 3'h0, 6'h00, 8'h00);
		chk8(cpu.got_rd, e);
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] w);
		cpu.issue(dsd_pkg::K_STORE, dsd_pkg::M_DIRECT, dsd_pkg::P_X, a, 6'h00, 3'h0, 6'h00, w);
		chk1(cpu.got_err, 1'b0);
	endtask
	// Bounded wait for the self-timed write to finish
	task automatic wait_idle;
		n = 0;
		while (nvm_busy && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk1(nvm_busy, 1'b0);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Generous limit: the whole sequence needs well under 2000 cycles
	initial
	begin
		#200000;
		fails++;
		stop_test;
	end
	initial
	begin
		{rst_n, por_n, gpr_we, gpr_wr_addr, gpr_wr_data, flag_set} = '0;
		gpr_rd_addr = 5'h06;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		por_n = 1'b1;
		for (int i = 0; i < 21; i++)
		begin
			r = rows[i];
			cpu.issue(dsd_pkg::dsd_kind_t'(r.k), dsd_pkg::M_DIRECT, dsd_pkg::P_X, r.a, r.io, r.b, 6'h00, r.w);
			chk1(cpu.got_err, r.eerr);
			if (r.cmp)
				chk8(cpu.got_rd, r.erd);
			if (r.k[2] & r.k[1])
				chk1(cpu.got_skip, r.esk);
			chk8(8'(cpu.lat), {5'h00, r.lat});
		end
		$display("test table done");
		gpr_wr_addr = 5'h05;
		gpr_wr_data = 8'hc3;
		gpr_we = 1'b1;
		@(posedge clk);
		#1;
		gpr_we = 1'b0;
		ld(16'h0005, 8'hc3);
		st(16'h0006, 8'h5e);
		chk8(gpr_rd_data, 8'h5e);
		$display("test register file done");
		st(16'h001a, 8'h00);
		st(16'h001b, 8'h01);
		cpu.issue(dsd_pkg::K_STORE, dsd_pkg::M_POSTINC, dsd_pkg::P_X, 16'h0000, 6'h00, 3'h0, 6'h00, 8'h21);
		ld(16'h001a, 8'h01);
		cpu.issue(dsd_pkg::K_LOAD, dsd_pkg::M_PREDEC, dsd_pkg::P_X, 16'h0000, 6'h00, 3'h0, 6'h00, 8'h00);
		chk8(cpu.got_rd, 8'h21);
		ld(16'h001a, 8'h00);
		st(16'h0400, 8'h3f);
		st(16'h001c, 8'hc1);
		st(16'h001d, 8'h03);
		cpu.issue(dsd_pkg::K_LOAD, dsd_pkg::M_DISP, dsd_pkg::P_Y, 16'h0000, 6'h00, 3'h0, 6'h3f, 8'h00);
		chk8(cpu.got_rd, 8'h3f);
		cpu.issue(dsd_pkg::K_LOAD, dsd_pkg::M_DISP, dsd_pkg::P_X, 16'h0000, 6'h00, 3'h0, 6'h01, 8'h00);
		chk1(cpu.got_err, 1'b1);
		$display("test pointers done");
		flag_set = 8'h81;
		@(posedge clk);
		#1;
		flag_set = 8'h00;
		ld(16'h0038, 8'h81);
		st(16'h0038, 8'h01);
		ld(16'h0038, 8'h80);
		flag_set = 8'h01;
		@(posedge clk);
		#1;
		flag_set = 8'h00;
		cpu.issue(dsd_pkg::K_BIT_SET, dsd_pkg::M_DIRECT, dsd_pkg::P_X, 16'h0000, 6'h18, 3'h0, 6'h00, 8'h00);
		ld(16'h0038, 8'h80);
		$display("test flags done");
		st(16'h0032, 8'h05);
		st(16'h0033, 8'h00);
		st(16'h0031, 8'h6b);
		st(16'h0030, 8'h02);
		chk1(nvm_busy, 1'b0);
		cpu.nvm_prog(8'h00);
		chk8(8'(cpu.lat), 8'h03);
		chk1(nvm_busy, 1'b1);
		wait_idle;
		st(16'h0031, 8'h00);
		st(16'h0030, 8'h01);
		chk8(8'(cpu.lat), 8'h05);
		ld(16'h0031, 8'h6b);
		st(16'h0030, 8'h04);
		repeat (6) @(posedge clk);
		#1;
		st(16'h0030, 8'h02);
		chk1(nvm_busy, 1'b0);
		$display("test nvm done");
		st(16'h0031, 8'h3c);
		cpu.nvm_prog(8'h00);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk1(nvm_busy, 1'b1);
		wait_idle;
		st(16'h0032, 8'h05);
		st(16'h0030, 8'h01);
		ld(16'h0031, 8'h3c);
		$display("test reset during write done");
		// Erase-only, then write-only over the erased byte, then the reserved mode
		cpu.nvm_prog(8'h10);
		wait_idle;
		st(16'h0030, 8'h01);
		ld(16'h0031, 8'hff);
		st(16'h0031, 8'h0f);
		cpu.nvm_prog(8'h20);
		wait_idle;
		st(16'h0030, 8'h01);
		ld(16'h0031, 8'h0f);
		cpu.nvm_prog(8'h30);
		chk1(nvm_busy, 1'b0);
		st(16'h0030, 8'h08);
		chk1(nvm_rdy, 1'b1);
		$display("test nvm modes done");
		stop_test;
	end
endmodule // testbench
